// >>> logic/lcm_csr.sv
// Implementation choices: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
// Function
// - specific mask bits 31:26 block the interrupt of their event
// - writing one to bit 25 raises a software interrupt; zero does nothing
// - global mask bit 24 set keeps the interrupt line deasserted
// - global mask overrides specific masks and software interrupt
// - four-bit command-unit code at 23:20 is passed on when written
// - three-bit receive-unit code at 18:16; host writes bit 19 as zero
// - 32-bit general pointer register for command structures
// - port register low four bits select function, upper bits operand
// - management interrupt enable raises interrupt at each cycle end
// - ready bit set when management transaction finishes
// - opcode 01 writes, 10 reads; 00 and 11 are never started
// - five-bit PHY and register addresses go into the frame
// - write data 15:0 is sent to the PHY
// - read data shifted in serially and left in 15:0
// - receive byte counter sums bytes moved to host memory
// - early receive interrupt by frame length, flag plus interrupt
// - flow control command field selects pause, on or off
// - flow threshold compared against free receive FIFO bytes
// - management completion sets status flag bit 11
// - early receive reported in status flag bit 9
module lcm_csr
  import lcm_pkg::*;
#(
  parameter int MDC_HALF = MDC_HALF_CYC // system clocks per management half
)
(
  input  wire logic        clk_sys_i,       // 50 MHz system clock
  input  wire logic        rst_n_i,         // synchronous reset, active low
  input  wire logic [5:0]  avs_address_i,   // byte address
  input  wire logic        avs_read_i,      // read request
  input  wire logic        avs_write_i,     // write request
  input  wire logic [3:0]  avs_byteenable_i,// write byte lanes
  input  wire logic [31:0] avs_writedata_i, // write data
  output logic [31:0]      avs_readdata_o,  // read data
  output logic             avs_waitrequest_o,// stall request
  input  wire logic        cu_exec_evt_i,   // command executed pulse
  input  wire logic        frame_rx_evt_i,  // frame received pulse
  input  wire logic        cu_idle_evt_i,   // command engine idle pulse
  input  wire logic        ru_nready_evt_i, // receive engine not ready
  input  wire logic [1:0]  cu_status_i,     // command engine state
  input  wire logic [3:0]  ru_status_i,     // receive engine state
  output logic             cu_cmd_valid_o,  // command code pulse
  output logic [3:0]       command_unit_cmd_o, // command code
  output logic             ru_cmd_valid_o,  // receive code pulse
  output logic [2:0]       receive_unit_cmd_o, // receive code
  output logic [31:0]      gen_ptr_o,       // general pointer
  output logic             port_valid_o,    // port function pulse
  output logic [3:0]       port_func_o,     // port function code
  output logic [27:0]      port_operand_o,  // port address or data
  output logic             port_known_o,    // code is one of the four
  input  wire logic        rx_dma_valid_i,  // bytes moved this cycle
  input  wire logic [7:0]  rx_dma_bytes_i,  // byte count moved
  input  wire logic        rx_frame_start_i,// new frame begins
  input  wire logic [15:0] rx_frame_len_i,  // bytes of frame so far
  input  wire logic [15:0] rx_fifo_free_i,  // free receive FIFO bytes
  output logic [2:0]       fc_cmd_o,        // flow control command
  output logic             fc_pause_req_o,  // free space under threshold
  output logic             mdc_o,           // management clock
  output logic             mdio_o,          // management data out
  output logic             mdio_oe_o,       // management data enable
  input  wire logic        mdio_i,          // management data in
  output logic             inta_n_o         // interrupt line, active low
);

  // merge written byte lanes into an old value
  function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                           input logic [31:0] new_v,
                                           input logic [3:0]  be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    return r;
  endfunction : be_merge

  // true when port code is one of the four supported functions
  function automatic logic port_code_ok(input logic [3:0] c);
    return (c == PORT_SW_RESET) || (c == PORT_SELF_TEST) ||
           (c == PORT_SEL_RESET) || (c == PORT_DUMP);
  endfunction : port_code_ok

  logic          ack_reg;
  logic [31:0]   rdata_reg;
  logic          wr_go;
  logic [15:0]   cmd_reg;
  logic [7:0]    flag_reg;
  logic [31:0]   ptr_reg;
  logic [31:0]   port_reg;
  logic [31:0]   mg_reg;
  logic [31:0]   rxcnt_reg;
  logic [15:0]   er_thr_reg;
  logic          er_armed_reg;
  logic [18:0]   flow_reg;
  logic          pause_prev_reg;
  logic          cu_v_reg;
  logic          ru_v_reg;
  logic          port_v_reg;
  logic          inta_n_reg;
  logic          mdio_s1_reg;
  logic          mdio_s2_reg;
  lcm_mg_state_t mg_state_reg;
  logic [63:0]   frame_reg;
  logic [5:0]    bit_reg;
  logic [15:0]   div_reg;
  logic          mdc_reg;
  logic          oe_reg;
  logic [15:0]   rd_sh_reg;
  logic          mg_is_read_reg;
  logic          tick;
  logic          er_hit;
  logic          pause_now;
  logic [7:0]    flag_set;
  logic [5:0]    spec_src;
  logic          pending;
  logic          mg_start;
  logic [31:0]   wr_mg;

  // one wait cycle per access; write lands when wait drops
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack_reg;
  assign wr_go             = avs_write_i & ack_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ack_reg <= 1'b0;
    else
      ack_reg <= (avs_read_i | avs_write_i) & ~ack_reg;
  end

  // read mux captured in the wait cycle; unmapped reads give zero
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rdata_reg <= 32'h0000_0000;
    else if (avs_read_i && !ack_reg)
    begin
      case (avs_address_i)
        ADDR_CMD_STAT: rdata_reg <= {cmd_reg, flag_reg, cu_status_i,
                                     ru_status_i, 2'h0};
        ADDR_GEN_PTR:  rdata_reg <= ptr_reg;
        ADDR_PORT:     rdata_reg <= port_reg;
        ADDR_MGMT:     rdata_reg <= mg_reg;
        ADDR_RX_BYTES: rdata_reg <= rxcnt_reg;
        ADDR_EARLY_RX: rdata_reg <= {16'h0000, er_thr_reg};
        ADDR_FLOW:     rdata_reg <= {13'h0000, flow_reg};
        default:       rdata_reg <= 32'h0000_0000;
      endcase
    end
  end
  assign avs_readdata_o = rdata_reg;

  // command word; software interrupt bit is write-only, reads zero
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      cmd_reg  <= 16'h0000;
      cu_v_reg <= 1'b0;
      ru_v_reg <= 1'b0;
    end
    else
    begin
      cu_v_reg <= 1'b0;
      ru_v_reg <= 1'b0;
      if (wr_go && avs_address_i == ADDR_CMD_STAT)
      begin
        if (avs_byteenable_i[3])
          cmd_reg[15:8] <= {avs_writedata_i[31:26], 1'b0,
                            avs_writedata_i[24]};
        if (avs_byteenable_i[2])
        begin
          cmd_reg[7:4] <= avs_writedata_i[CU_CMD_HI:CU_CMD_LO];
          cmd_reg[3:0] <= {1'b0, avs_writedata_i[RU_CMD_HI:RU_CMD_LO]};
          cu_v_reg     <= 1'b1;
          ru_v_reg     <= 1'b1;
        end
      end
    end
  end
  assign cu_cmd_valid_o     = cu_v_reg;
  assign ru_cmd_valid_o     = ru_v_reg;
  assign command_unit_cmd_o = cmd_reg[7:4];
  assign receive_unit_cmd_o = cmd_reg[2:0];

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      ptr_reg <= 32'h0000_0000;
    else if (wr_go && avs_address_i == ADDR_GEN_PTR)
      ptr_reg <= be_merge(ptr_reg, avs_writedata_i, avs_byteenable_i);
  end
  assign gen_ptr_o = ptr_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      port_reg   <= 32'h0000_0000;
      port_v_reg <= 1'b0;
    end
    else
    begin
      port_v_reg <= wr_go && avs_address_i == ADDR_PORT &&
                    avs_byteenable_i[0];
      if (wr_go && avs_address_i == ADDR_PORT)
        port_reg <= be_merge(port_reg, avs_writedata_i, avs_byteenable_i);
    end
  end
  assign port_valid_o   = port_v_reg;
  assign port_func_o    = port_reg[3:0];
  assign port_operand_o = port_reg[31:4];
  assign port_known_o   = port_code_ok(port_reg[3:0]);

  // running receive byte count; any write clears it
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      rxcnt_reg <= 32'h0000_0000;
    else if (wr_go && avs_address_i == ADDR_RX_BYTES)
      rxcnt_reg <= 32'h0000_0000;
    else if (rx_dma_valid_i)
      rxcnt_reg <= rxcnt_reg + {24'h000000, rx_dma_bytes_i};
  end

  // early receive fires once per frame at the length threshold
  assign er_hit = er_armed_reg && (er_thr_reg != 16'h0000) &&
                  (rx_frame_len_i >= er_thr_reg);
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      er_thr_reg   <= 16'h0000;
      er_armed_reg <= 1'b0;
    end
    else
    begin
      if (wr_go && avs_address_i == ADDR_EARLY_RX)
        er_thr_reg <= 16'(be_merge({16'h0000, er_thr_reg},
                                   avs_writedata_i, avs_byteenable_i));
      if (rx_frame_start_i)
        er_armed_reg <= 1'b1;
      else if (er_hit)
        er_armed_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      flow_reg       <= {FC_OFF, 16'h0000};
      pause_prev_reg <= 1'b0;
    end
    else
    begin
      if (wr_go && avs_address_i == ADDR_FLOW)
        flow_reg <= 19'(be_merge({13'h0000, flow_reg}, avs_writedata_i,
                                 avs_byteenable_i));
      pause_prev_reg <= pause_now;
    end
  end
  assign pause_now      = (flow_reg[18:16] != FC_OFF) &&
                          (rx_fifo_free_i < flow_reg[15:0]);
  assign fc_cmd_o       = flow_reg[18:16];
  assign fc_pause_req_o = pause_prev_reg;

  // status flags: set wins over write-one-to-clear
  assign flag_set[FLG_CX]  = cu_exec_evt_i;
  assign flag_set[FLG_FR]  = frame_rx_evt_i;
  assign flag_set[FLG_CNA] = cu_idle_evt_i;
  assign flag_set[FLG_RNR] = ru_nready_evt_i;
  assign flag_set[FLG_MGT] = (mg_state_reg == MG_DONE);
  // only a written one raises software interrupt
  assign flag_set[FLG_SWI] = wr_go && avs_address_i == ADDR_CMD_STAT &&
                             avs_byteenable_i[3] &&
                             avs_writedata_i[SW_INT_BIT];
  assign flag_set[FLG_ER]  = er_hit;
  assign flag_set[FLG_FCP] = pause_now && !pause_prev_reg;

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      flag_reg <= 8'h00;
    else if (wr_go && avs_address_i == ADDR_CMD_STAT && avs_byteenable_i[1])
      flag_reg <= (flag_reg & ~avs_writedata_i[15:8]) | flag_set;
    else
      flag_reg <= flag_reg | flag_set;
  end

  // specific masks map onto cx, fr, cna, rnr, er, fcp
  assign spec_src = {flag_reg[FLG_CX], flag_reg[FLG_FR], flag_reg[FLG_CNA],
                     flag_reg[FLG_RNR], flag_reg[FLG_ER], flag_reg[FLG_FCP]};
  // pending source; management gated by its enable
  assign pending  = |(spec_src & ~cmd_reg[15:10]) | flag_reg[FLG_SWI] |
                    (flag_reg[FLG_MGT] & mg_reg[MG_IE_BIT]);

  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      inta_n_reg <= 1'b1;
    else
      inta_n_reg <= ~(pending & ~cmd_reg[8]);
  end
  assign inta_n_o = inta_n_reg;

  // management data pin synchroniser
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      mdio_s1_reg <= 1'b0;
      mdio_s2_reg <= 1'b0;
    end
    else
    begin
      mdio_s1_reg <= mdio_i;
      mdio_s2_reg <= mdio_s1_reg;
    end
  end

  // writes while a frame runs are ignored to keep the frame coherent
  assign wr_mg    = be_merge(mg_reg, avs_writedata_i, avs_byteenable_i);
  // reserved opcodes never start a frame
  assign mg_start = wr_go && avs_address_i == ADDR_MGMT &&
                    mg_state_reg == MG_IDLE &&
                    (wr_mg[27:26] == MG_OP_WRITE ||
                     wr_mg[27:26] == MG_OP_READ);
  // half periods under three clocks would sample read bits before the
  // synchroniser has passed them on
  assign tick     = (div_reg == 16'(MDC_HALF - 1));

  // management control register, ready and read data
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      mg_reg <= 32'h0000_0000;
    else if (mg_state_reg == MG_DONE)
    begin
      mg_reg[MG_RDY_BIT] <= 1'b1;
      if (mg_is_read_reg)
        mg_reg[15:0] <= rd_sh_reg;
    end
    else if (wr_go && avs_address_i == ADDR_MGMT &&
             mg_state_reg == MG_IDLE)
      mg_reg <= {2'h0, wr_mg[29:0]};
  end

  // frame sequencer
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
      mg_state_reg <= MG_IDLE;
    else
    begin
      case (mg_state_reg)
        MG_IDLE:  if (mg_start) mg_state_reg <= MG_SHIFT;
        MG_SHIFT: if (tick && mdc_reg && bit_reg == 6'h3F)
                    mg_state_reg <= MG_DONE;
        MG_DONE:  mg_state_reg <= MG_IDLE;
        default:  mg_state_reg <= MG_IDLE;
      endcase
    end
  end

  // serial frame; bits change on falling, sampled on rising
  always_ff @(posedge clk_sys_i)
  begin
    if (!rst_n_i)
    begin
      frame_reg      <= 64'h0;
      bit_reg        <= 6'h00;
      div_reg        <= 16'h0000;
      mdc_reg        <= 1'b0;
      oe_reg         <= 1'b0;
      rd_sh_reg      <= 16'h0000;
      mg_is_read_reg <= 1'b0;
    end
    else if (mg_start)
    begin
      frame_reg      <= {MG_PREAMBLE, MG_START, wr_mg[27:26], wr_mg[25:21],
                         wr_mg[20:16],
                         (wr_mg[27:26] == MG_OP_READ) ? 2'h0 : MG_TA_WRITE,
                         wr_mg[15:0]};
      mg_is_read_reg <= (wr_mg[27:26] == MG_OP_READ);
      bit_reg        <= 6'h00;
      div_reg        <= 16'h0000;
      mdc_reg        <= 1'b0;
      oe_reg         <= 1'b1;
    end
    else if (mg_state_reg == MG_SHIFT)
    begin
      div_reg <= tick ? 16'h0000 : div_reg + 16'h0001;
      if (tick && !mdc_reg)
      begin
        mdc_reg <= 1'b1;
        if (mg_is_read_reg && bit_reg >= 6'(MG_DATA_IDX))
          rd_sh_reg <= {rd_sh_reg[14:0], mdio_s2_reg};
      end
      else if (tick && mdc_reg)
      begin
        mdc_reg   <= 1'b0;
        frame_reg <= {frame_reg[62:0], 1'b0};
        bit_reg   <= bit_reg + 6'h01;
        // release the line after the last bit, or from turnaround for a read
        if (bit_reg == 6'h3F)
          oe_reg <= 1'b0;
        else if (mg_is_read_reg && bit_reg + 6'h01 >= 6'(MG_TA_IDX))
          oe_reg <= 1'b0;
      end
    end
  end
  assign mdc_o     = mdc_reg;
  assign mdio_o    = frame_reg[63] & oe_reg;
  assign mdio_oe_o = oe_reg;

  // checks
  property p_gmask;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    cmd_reg[8] |=> inta_n_o;
  endproperty
  a_gmask: assert property (p_gmask) else $error("masked line asserted");

  property p_prec;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (cmd_reg[8] && flag_reg[FLG_SWI]) |=> inta_n_o;
  endproperty
  a_prec: assert property (p_prec) else $error("mask lost precedence");

  property p_spec;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    ((spec_src & ~cmd_reg[15:10]) == 6'h00 && !flag_reg[FLG_SWI] &&
     !(flag_reg[FLG_MGT] && mg_reg[MG_IE_BIT])) |=> inta_n_o;
  endproperty
  a_spec: assert property (p_spec) else $error("masked event fired");

  property p_assert;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (pending && !cmd_reg[8]) |=> !inta_n_o;
  endproperty
  a_assert: assert property (p_assert) else $error("line not raised");

  property p_swi;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    flag_set[FLG_SWI] |=> flag_reg[FLG_SWI];
  endproperty
  a_swi: assert property (p_swi) else $error("soft irq not set");

  sequence s_mg_end;
    mg_state_reg == MG_DONE;
  endsequence
  property p_ready;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    s_mg_end |=> mg_reg[MG_RDY_BIT] && flag_reg[FLG_MGT];
  endproperty
  a_ready: assert property (p_ready) else $error("ready not set");

  property p_op;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    $rose(mg_state_reg == MG_SHIFT) |->
      (mg_reg[27:26] == MG_OP_WRITE || mg_reg[27:26] == MG_OP_READ);
  endproperty
  a_op: assert property (p_op) else $error("reserved opcode run");

  property p_pre;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mg_state_reg == MG_SHIFT && bit_reg < 6'h20) |-> mdio_o && mdio_oe_o;
  endproperty
  a_pre: assert property (p_pre) else $error("preamble not ones");

  property p_rel;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (mg_state_reg == MG_SHIFT && mg_is_read_reg && bit_reg >= 6'h2E)
      |-> !mdio_oe_o;
  endproperty
  a_rel: assert property (p_rel) else $error("read drives line");

  property p_cu;
    @(posedge clk_sys_i) disable iff (!rst_n_i)
    (wr_go && avs_address_i == ADDR_CMD_STAT && avs_byteenable_i[2])
      |=> cu_cmd_valid_o &&
          command_unit_cmd_o == $past(avs_writedata_i[23:20]);
  endproperty
  a_cu: assert property (p_cu) else $error("command code lost");

endmodule : lcm_csr

// >>> logic/lcm_pkg.sv
package lcm_pkg;

  // register byte addresses on the host bus
  localparam logic [5:0] ADDR_CMD_STAT = 6'h00;
  localparam logic [5:0] ADDR_GEN_PTR  = 6'h04;
  localparam logic [5:0] ADDR_PORT     = 6'h08;
  localparam logic [5:0] ADDR_MGMT     = 6'h10;
  localparam logic [5:0] ADDR_RX_BYTES = 6'h18;
  localparam logic [5:0] ADDR_EARLY_RX = 6'h1C;
  localparam logic [5:0] ADDR_FLOW     = 6'h20;

  // command word fields (upper half of the first register)
  localparam int SPEC_MASK_HI = 31;
  localparam int SPEC_MASK_LO = 26;
  localparam int SW_INT_BIT   = 25;
  localparam int GLOBAL_MASK  = 24;
  localparam int CU_CMD_HI    = 23;
  localparam int CU_CMD_LO    = 20;
  localparam int RU_CMD_HI    = 18;
  localparam int RU_CMD_LO    = 16;

  // status flag positions inside flag vector (status bits 15:8)
  localparam int FLG_CX  = 7;
  localparam int FLG_FR  = 6;
  localparam int FLG_CNA = 5;
  localparam int FLG_RNR = 4;
  localparam int FLG_MGT = 3;
  localparam int FLG_SWI = 2;
  localparam int FLG_ER  = 1;
  localparam int FLG_FCP = 0;

  // management control fields
  localparam int MG_IE_BIT  = 29;
  localparam int MG_RDY_BIT = 28;
  localparam logic [1:0] MG_OP_WRITE = 2'h1;
  localparam logic [1:0] MG_OP_READ  = 2'h2;
  localparam logic [1:0] MG_TA_WRITE = 2'h2;
  localparam logic [1:0] MG_START    = 2'h1;
  localparam logic [31:0] MG_PREAMBLE = 32'hFFFF_FFFF;
  localparam int MG_FRAME_BITS = 64;
  localparam int MG_TA_IDX     = 46;
  localparam int MG_DATA_IDX   = 48;

  // port function select codes
  localparam logic [3:0] PORT_SW_RESET  = 4'h0;
  localparam logic [3:0] PORT_SELF_TEST = 4'h1;
  localparam logic [3:0] PORT_SEL_RESET = 4'h2;
  localparam logic [3:0] PORT_DUMP      = 4'h3;

  // flow control command codes
  localparam logic [2:0] FC_OFF   = 3'h0;
  localparam logic [2:0] FC_ON    = 3'h1;
  localparam logic [2:0] FC_PAUSE = 3'h2;

  // timing: management clock half period, least time
  localparam int CLK_PERIOD_NS = 20;
  localparam int MDC_HALF_NS   = 200;
  localparam int MDC_HALF_CYC  =
    (MDC_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  typedef enum logic [2:0]
  {
    MG_IDLE  = 3'b001,
    MG_SHIFT = 3'b010,
    MG_DONE  = 3'b100
  } lcm_mg_state_t;

endpackage : lcm_pkg

// >>> tb/lcm_phy_model.sv
`timescale 1ns/1ps
module lcm_phy_model
(
  input  wire logic        mdc_i,     // management clock
  input  wire logic        line_i,    // resolved data line
  input  wire logic [15:0] rd_data_i, // value served on reads
  output logic             phy_oe_o,  // high while driving
  output logic             phy_d_o,   // driven bit
  output logic [63:0]      frame_o    // last 64 bits on the line
);
  logic [5:0] cnt = 6'h00;
  logic       rd  = 1'h0;
  initial frame_o = 64'h0;
  initial phy_oe_o = 1'h0;
  initial phy_d_o = 1'h0;
  // sample rising edges
  // a frame is 64 rises, so the counter wraps by itself
  always @(posedge mdc_i)
  begin
    frame_o <= {frame_o[62:0], line_i};
    cnt     <= cnt + 6'h01;
    if (cnt == 6'h23)
      rd <= ({frame_o[0], line_i} == 2'h2);
  end
  // serve reads
  // turnaround low on bit 47, data msb first, then release to pull-up
  always @(negedge mdc_i)
  begin
    phy_oe_o <= rd && (cnt >= 6'h2F);
    phy_d_o  <= (cnt >= 6'h30) ? rd_data_i[6'h3F - cnt] : 1'h0;
  end
endmodule : lcm_phy_model

// >>> tb/tb_lcm_csr.sv
`timescale 1ns/1ps
module tb_lcm_csr;
  import lcm_pkg::*;
  typedef struct packed
  {
    logic [5:0]  a;
    logic [31:0] d;
    logic [31:0] e;
  } lcm_row_t;
  logic        clk_sys_i = 1'h0;
  logic        rst_n_i   = 1'h0;
  logic        rd = 1'h0, wr = 1'h0, dv = 1'h0, fs = 1'h0;
  logic [3:0]  ev  = 4'h0, be = 4'hF;
  logic [5:0]  adr = 6'h00;
  logic [7:0]  nb  = 8'h00;
  logic [15:0] len = 16'h0000, fr = 16'hFFFF;
  logic [31:0] wd  = 32'h0, q, rdo, ptr;
  logic [3:0]  command_unit_cmd, pf;
  logic [2:0]  receive_unit_cmd, fcc;
  logic        wt, cuv, ruv, pv, pk, fp, mdc, mdo, oe, inta_n, poe, pd;
  logic [63:0] frm;
  logic [27:0] pop;
  // pull-up on the management line when nobody drives
  wire         ln = oe ? mdo : (poe ? pd : 1'h1);
  int          bad_count = 0, checked = 0, cyc = 0;
  lcm_row_t    rows [5];

  // three clocks a half at least: read bits cross a two-flop synchroniser
  lcm_csr #(.MDC_HALF(3)) lcm_csr_inst (.clk_sys_i, .rst_n_i,
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_byteenable_i(be), .avs_writedata_i(wd), .avs_readdata_o(rdo),
    .avs_waitrequest_o(wt), .cu_exec_evt_i(ev[3]), .frame_rx_evt_i(ev[2]),
    .cu_idle_evt_i(ev[1]), .ru_nready_evt_i(ev[0]), .cu_status_i(2'h1),
    .ru_status_i(4'h3), .cu_cmd_valid_o(cuv), .command_unit_cmd_o(command_unit_cmd),
    .ru_cmd_valid_o(ruv), .receive_unit_cmd_o(receive_unit_cmd), .gen_ptr_o(ptr),
    .port_valid_o(pv), .port_func_o(pf), .port_operand_o(pop),
    .port_known_o(pk), .rx_dma_valid_i(dv), .rx_dma_bytes_i(nb),
    .rx_frame_start_i(fs), .rx_frame_len_i(len), .rx_fifo_free_i(fr),
    .fc_cmd_o(fcc), .fc_pause_req_o(fp), .mdc_o(mdc), .mdio_o(mdo),
    .mdio_oe_o(oe), .mdio_i(ln), .inta_n_o(inta_n));
  lcm_phy_model lcm_phy_model_inst (.mdc_i(mdc), .line_i(ln),
    .rd_data_i(16'hC3A5), .phy_oe_o(poe), .phy_d_o(pd), .frame_o(frm));

  always #10 clk_sys_i = ~clk_sys_i;

  task automatic tally_and_finish();
    if (bad_count == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string n, input logic [31:0] s, e);
    checked++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask : chk

  // one bus access, held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [5:0] a,
                     input logic [31:0] d);
    @(posedge clk_sys_i);
    adr <= a;
    wr  <= w;
    rd  <= !w;
    wd  <= d;
    do @(posedge clk_sys_i); while (wt !== 1'h0);
    // write lands and read data is taken at this same edge
    q = rdo;
    rd <= 1'h0;
    wr <= 1'h0;
  endtask : acc

  // interrupt line settles within a few cycles of its cause
  task automatic ick(input logic e);
    repeat (3) @(negedge clk_sys_i);
    chk("inta_n", 32'(inta_n), 32'(e));
  endtask : ick

  task automatic pls(input logic [3:0] v);
    @(posedge clk_sys_i);
    ev <= v;
    @(posedge clk_sys_i);
    ev <= 2'h0;
  endtask : pls

  // poll until the management ready bit comes up
  task automatic mwait();
    do acc(1'h0, ADDR_MGMT, 32'h0); while (q[28] !== 1'h1);
  endtask : mwait

  // hang guard
  always @(posedge clk_sys_i)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      bad_count++;
      tally_and_finish();
    end
  end

  initial
  begin
    rows = '{'{ADDR_GEN_PTR, 32'hA5A5_5A5A, 32'hA5A5_5A5A},
             '{ADDR_PORT, 32'h1234_5673, 32'h1234_5673},
             '{ADDR_FLOW, 32'h0002_0100, 32'h0002_0100},
             '{ADDR_CMD_STAT, 32'hFDA2_0000, 32'hFDA2_004C},
             '{6'h3C, 32'hFFFF_FFFF, 32'h0}};
    repeat (20) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    acc(1'h0, ADDR_CMD_STAT, 32'h0);
    chk("reset status", q, 32'h4C);
    foreach (rows[i])
    begin
      acc(1'h1, rows[i].a, rows[i].d);
      acc(1'h0, rows[i].a, 32'h0);
      chk("readback", q, rows[i].e);
    end
    chk("pointer", ptr, 32'hA5A5_5A5A);
    chk("flow cmd", 32'(fcc), 32'(FC_PAUSE));
    // only the two middle lanes are enabled
    be <= 4'h6;
    acc(1'h1, ADDR_GEN_PTR, 32'h1234_5678);
    be <= 4'hF;
    @(negedge clk_sys_i);
    chk("lane merge", ptr, 32'hA534_565A);
    acc(1'h1, ADDR_CMD_STAT, 32'h0151_0000);
    @(negedge clk_sys_i);
    chk("cu pulse", 32'(cuv), 32'h1);
    chk("ru pulse", 32'(ruv), 32'h1);
    chk("cu code", 32'(command_unit_cmd), 32'h5);
    chk("ru code", 32'(receive_unit_cmd), 32'h1);
    for (int k = 0; k < 5; k++)
    begin
      acc(1'h1, ADDR_PORT, 32'h0000_0AB0 | k);
      @(negedge clk_sys_i);
      chk("port pulse", 32'(pv), 32'h1);
      chk("port fn", 32'(pf), k);
      chk("port operand", 32'(pop), 32'hAB);
      chk("port known", 32'(pk), k < 4);
    end
    acc(1'h1, ADDR_CMD_STAT, 32'h0300_0000);
    ick(1'h1);
    acc(1'h1, ADDR_CMD_STAT, 32'h0);
    ick(1'h0);
    acc(1'h1, ADDR_CMD_STAT, 32'h4000_0400);
    ick(1'h1);
    pls(4'h4);
    ick(1'h1);
    pls(4'hB);
    ick(1'h0);
    acc(1'h0, ADDR_CMD_STAT, 32'h0);
    chk("event flags", 32'(q[15:12]), 32'hF);
    acc(1'h1, ADDR_CMD_STAT, 32'h0000_F000);
    acc(1'h1, ADDR_MGMT, 32'h26AA_BEEF);
    mwait();
    chk("mgmt wr", q, 32'h36AA_BEEF);
    chk("preamble", frm[63:32], 32'hFFFF_FFFF);
    chk("wr frame", frm[31:0], 32'h5AAA_BEEF);
    ick(1'h0);
    acc(1'h0, ADDR_CMD_STAT, 32'h0);
    chk("mgmt flag", 32'(q[11]), 32'h1);
    acc(1'h1, ADDR_CMD_STAT, 32'h0000_0800);
    acc(1'h1, ADDR_MGMT, 32'h0B23_0000);
    mwait();
    chk("mgmt rd", q, 32'h1B23_C3A5);
    chk("rd frame", frm[31:0], 32'h6C8E_C3A5);
    ick(1'h1);
    acc(1'h1, ADDR_CMD_STAT, 32'h0000_0800);
    acc(1'h1, ADDR_MGMT, 32'h0C00_1234);
    repeat (8) @(negedge clk_sys_i);
    chk("reserved op", 32'(oe), 32'h0);
    @(posedge clk_sys_i);
    dv <= 1'h1;
    nb <= 8'h40;
    @(posedge clk_sys_i);
    nb <= 8'h25;
    @(posedge clk_sys_i);
    dv <= 1'h0;
    acc(1'h0, ADDR_RX_BYTES, 32'h0);
    chk("dma count", q, 32'h65);
    acc(1'h1, ADDR_RX_BYTES, 32'h0);
    acc(1'h0, ADDR_RX_BYTES, 32'h0);
    chk("dma clear", q, 32'h0);
    acc(1'h1, ADDR_EARLY_RX, 32'h40);
    @(posedge clk_sys_i);
    fs <= 1'h1;
    @(posedge clk_sys_i);
    fs  <= 1'h0;
    len <= 16'h0040;
    ick(1'h0);
    acc(1'h0, ADDR_CMD_STAT, 32'h0);
    chk("early flag", 32'(q[9]), 32'h1);
    fr <= 16'h00FF;
    repeat (3) @(negedge clk_sys_i);
    chk("pause", 32'(fp), 32'h1);
    @(posedge clk_sys_i);
    fr <= 16'h0100;
    repeat (3) @(negedge clk_sys_i);
    chk("no pause", 32'(fp), 32'h0);
    // mid-run reset: stored state cleared, pending pause flag dropped
    @(posedge clk_sys_i);
    rst_n_i <= 1'h0;
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'h1;
    acc(1'h0, ADDR_GEN_PTR, 32'h0);
    chk("reset ptr", q, 32'h0);
    chk("reset flow", 32'(fcc), 32'(FC_OFF));
    chk("reset irq", 32'(inta_n), 32'h1);
    tally_and_finish();
  end
endmodule : tb_lcm_csr
